// ===== logic/csp_pkg.sv
package csp_pkg;
	typedef logic [7:0] csp_byte_t;
	typedef logic [2:0] csp_txsel_t;
	typedef logic [1:0] csp_rxsel_t;

	// instruction bytes and decode fields
	localparam csp_byte_t CMD_RESET     = 8'hc0;
	localparam csp_byte_t CMD_READ      = 8'h03;
	localparam csp_byte_t CMD_WRITE     = 8'h02;
	localparam csp_byte_t CMD_BITMOD    = 8'h05;
	localparam csp_byte_t CMD_RDSTAT    = 8'ha0;
	localparam csp_byte_t CMD_RXSTAT    = 8'hb0;
	localparam csp_byte_t RXRD_PATTERN  = 8'h90;
	localparam csp_byte_t RXRD_MASK     = 8'hf9;
	localparam csp_byte_t TXLD_PATTERN  = 8'h40;
	localparam csp_byte_t TXLD_MASK     = 8'hf8;
	localparam csp_byte_t RTS_PATTERN   = 8'h80;
	localparam csp_byte_t RTS_MASK      = 8'hf8;
	localparam int        RXRD_N_BIT    = 2;
	localparam int        RXRD_M_BIT    = 1;

	// pointer start locations
	localparam csp_byte_t RXB0_ID_ADDR  = 8'h61;
	localparam csp_byte_t RXB0_DAT_ADDR = 8'h66;
	localparam csp_byte_t RXB1_ID_ADDR  = 8'h71;
	localparam csp_byte_t RXB1_DAT_ADDR = 8'h76;
	localparam csp_byte_t TXB0_ID_ADDR  = 8'h31;
	localparam csp_byte_t TXB0_DAT_ADDR = 8'h36;
	localparam csp_byte_t TXB1_ID_ADDR  = 8'h41;
	localparam csp_byte_t TXB1_DAT_ADDR = 8'h46;
	localparam csp_byte_t TXB2_ID_ADDR  = 8'h51;
	localparam csp_byte_t TXB2_DAT_ADDR = 8'h56;

	localparam csp_byte_t FULL_MASK     = 8'hff;
	localparam csp_byte_t BYTE_ZERO     = 8'h00;
	localparam logic [2:0] LAST_BIT     = 3'h7;
	localparam int        SYNC_STAGES   = 2;

	typedef enum logic [3:0] {
		ST_CMD,
		ST_ADDR,
		ST_RD,
		ST_WR,
		ST_MASK,
		ST_BMDATA,
		ST_RDSTAT,
		ST_RXSTAT,
		ST_IGNORE
	} csp_state_t;

	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_BITMOD
	} csp_op_t;
endpackage : csp_pkg

// ===== logic/csp_sync.sv
`timescale 1ns/1ps
module csp_sync (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] async_in,
	output logic      [2:0] sync_out
);
	import csp_pkg::*;

	logic [2:0] stage_q [SYNC_STAGES];

	// first stage only feeds the second; cs idles high so reset to that level
	genvar g;
	generate
		for (g = 0; g < SYNC_STAGES; g++) begin : g_stage
			// stage zero has no predecessor, so it gets its own branch of the loop
			if (g == 0) begin : g_first
				always_ff @(posedge sys_clk or posedge rst) begin
					if (rst) begin
						stage_q[g] <= 3'h2;
					end else begin
						stage_q[g] <= async_in;
					end
				end
			end else begin : g_next
				always_ff @(posedge sys_clk or posedge rst) begin
					if (rst) begin
						stage_q[g] <= 3'h2;
					end else begin
						stage_q[g] <= stage_q[g-1];
					end
				end
			end
		end
	endgenerate

	assign sync_out = stage_q[SYNC_STAGES-1];
endmodule : csp_sync

// ===== logic/csp_port.sv
`timescale 1ns/1ps
// Function
// - works in clock modes 0,0 and 1,1
// - serial input sampled on clock rise
// - serial output changes on clock fall
// - first byte is instruction; reselect for next
// - reset command restores defaults, configuration mode
// - reset equals pin reset, on select rise
// - read: command, address, then data out
// - pointer increments after each data byte
// - rx read preloads one of four starts
// - rx read clears its full flag at deselect
// - write: command, address, consecutive data bytes
// - byte commits on eighth bit; partial dropped
// - tx load preloads one of six starts
// - send request sets selected buffer request bits
// - send request with no selection ignored
// - read status returns poll status byte
// - rx status returns filter, type byte
// - unmodifiable register forces full mask
// - bit modify: address, mask, data byte
// - status keeps streaming while clocks continue
module csp_port (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              spi_sck,
	input  wire logic              spi_cs_n,
	input  wire logic              spi_si,
	output logic                   spi_so,
	output logic                   spi_so_oe,
	output csp_pkg::csp_byte_t     reg_addr,
	output logic                   reg_rd,
	input  wire csp_pkg::csp_byte_t reg_rdata,
	output logic                   reg_wr,
	output csp_pkg::csp_byte_t     reg_wdata,
	output csp_pkg::csp_byte_t     reg_wmask,
	input  wire logic              bitmod_ok,
	input  wire csp_pkg::csp_byte_t read_status,
	input  wire csp_pkg::csp_byte_t rx_status,
	output logic                   soft_reset,
	output csp_pkg::csp_txsel_t    tx_request_flag_set,
	output csp_pkg::csp_rxsel_t    rx_full_flag_clear
);
	import csp_pkg::*;

	logic [2:0] pins_s;
	logic       sck_s, cs_n_s, si_s;

	csp_sync u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({spi_sck, spi_cs_n, spi_si}),
		.sync_out (pins_s)
	);
	assign sck_s  = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign si_s   = pins_s[0];

	csp_state_t st_q, st_d;
	csp_op_t    op_q, op_d;
	logic       sck_prev_q, sck_prev_d;
	logic       cs_prev_q, cs_prev_d;
	logic [2:0] bit_q, bit_d;
	logic [6:0] in_q, in_d;
	csp_byte_t  addr_q, addr_d;
	csp_byte_t  out_q, out_d;
	csp_byte_t  nxt_q, nxt_d;
	logic       bdone_q, bdone_d;
	logic       rd_q, rd_d;
	logic       wr_q, wr_d;
	csp_byte_t  wdata_q, wdata_d;
	csp_byte_t  wmask_q, wmask_d;
	csp_byte_t  mask_q, mask_d;
	csp_txsel_t tx_request_flag_q, tx_request_flag_d;
	csp_rxsel_t rxclr_q, rxclr_d;
	logic       rxsel_q, rxsel_d;
	logic       rxrd_q, rxrd_d;
	logic       rstp_q, rstp_d;
	logic       srst_q, srst_d;
	logic       oe_q, oe_d;

	logic       cs_act, rise_w, fall_w, cs_rise, done_w;
	csp_byte_t  byte_w;

	// edges found on synchronised copies; sck and si see equal delay
	assign cs_act  = !cs_n_s;
	assign rise_w  = cs_act && sck_s && !sck_prev_q;
	assign fall_w  = cs_act && !sck_s && sck_prev_q;
	assign cs_rise = cs_n_s && !cs_prev_q;
	assign done_w  = rise_w && (bit_q == LAST_BIT);
	assign byte_w  = {in_q, si_s};

	always_comb begin
		st_d       = st_q;
		op_d       = op_q;
		sck_prev_d = sck_s;
		cs_prev_d  = cs_n_s;
		bit_d      = bit_q;
		in_d       = in_q;
		addr_d     = addr_q;
		out_d      = out_q;
		nxt_d      = nxt_q;
		bdone_d    = bdone_q;
		rd_d       = 1'b0;
		wr_d       = 1'b0;
		wdata_d    = wdata_q;
		wmask_d    = wmask_q;
		mask_d     = mask_q;
		tx_request_flag_d    = '0;
		rxclr_d    = '0;
		rxsel_d    = rxsel_q;
		rxrd_d     = rxrd_q;
		rstp_d     = rstp_q;
		srst_d     = 1'b0;
		oe_d       = cs_act;
		if (rd_q) begin
			nxt_d = reg_rdata;
		end
		// the write pulse must carry the old pointer, so step it a cycle later
		if (wr_q && st_q == ST_WR) begin
			addr_d = addr_q + 8'h01;
		end
		if (!cs_act) begin
			// a byte cut short never reaches the commit below
			st_d    = ST_CMD;
			bit_d   = '0;
			out_d   = BYTE_ZERO;
			bdone_d = 1'b0;
			rxrd_d  = 1'b0;
			rstp_d  = 1'b0;
			if (cs_rise && rxrd_q) begin
				rxclr_d[rxsel_q] = 1'b1;
			end
			if (cs_rise && rstp_q) begin
				srst_d = 1'b1;
			end
		end else begin
			if (fall_w) begin
				// new byte takes the fall after the last rise, so bit 7 is set up in time
				if (bdone_q) begin
					out_d   = nxt_q;
					bdone_d = 1'b0;
				end else begin
					out_d = {out_q[6:0], 1'b0};
				end
			end
			if (rise_w) begin
				in_d  = byte_w[6:0];
				bit_d = bit_q + 3'h1;
			end
			if (done_w) begin
				unique case (st_q)
					ST_CMD: begin
						st_d = ST_IGNORE;
						if (byte_w == CMD_RESET) begin
							rstp_d = 1'b1;
						end else if (byte_w == CMD_READ) begin
							st_d = ST_ADDR;
							op_d = OP_READ;
						end else if (byte_w == CMD_WRITE) begin
							st_d = ST_ADDR;
							op_d = OP_WRITE;
						end else if (byte_w == CMD_BITMOD) begin
							st_d = ST_ADDR;
							op_d = OP_BITMOD;
						end else if ((byte_w & RXRD_MASK) == RXRD_PATTERN) begin
							st_d    = ST_RD;
							rxrd_d  = 1'b1;
							rxsel_d = byte_w[RXRD_N_BIT];
							rd_d    = 1'b1;
							bdone_d = 1'b1;
							unique case ({byte_w[RXRD_N_BIT], byte_w[RXRD_M_BIT]})
								2'b00: addr_d = RXB0_ID_ADDR;
								2'b01: addr_d = RXB0_DAT_ADDR;
								2'b10: addr_d = RXB1_ID_ADDR;
								2'b11: addr_d = RXB1_DAT_ADDR;
							endcase
						end else if ((byte_w & TXLD_MASK) == TXLD_PATTERN) begin
							st_d = ST_WR;
							unique case (byte_w[2:0])
								3'h0: addr_d = TXB0_ID_ADDR;
								3'h1: addr_d = TXB0_DAT_ADDR;
								3'h2: addr_d = TXB1_ID_ADDR;
								3'h3: addr_d = TXB1_DAT_ADDR;
								3'h4: addr_d = TXB2_ID_ADDR;
								3'h5: addr_d = TXB2_DAT_ADDR;
								default: st_d = ST_IGNORE;
							endcase
						end else if ((byte_w & RTS_MASK) == RTS_PATTERN) begin
							// all-zero select leaves every request untouched
							tx_request_flag_d = byte_w[2:0];
						end else if (byte_w == CMD_RDSTAT) begin
							st_d    = ST_RDSTAT;
							nxt_d   = read_status;
							bdone_d = 1'b1;
						end else if (byte_w == CMD_RXSTAT) begin
							st_d    = ST_RXSTAT;
							nxt_d   = rx_status;
							bdone_d = 1'b1;
						end
					end
					ST_ADDR: begin
						addr_d = byte_w;
						unique case (op_q)
							OP_READ: begin
								st_d    = ST_RD;
								rd_d    = 1'b1;
								bdone_d = 1'b1;
							end
							OP_WRITE:  st_d = ST_WR;
							OP_BITMOD: st_d = ST_MASK;
							default:   st_d = ST_IGNORE;
						endcase
					end
					ST_RD: begin
						addr_d  = addr_q + 8'h01;
						rd_d    = 1'b1;
						bdone_d = 1'b1;
					end
					ST_WR: begin
						wr_d    = 1'b1;
						wdata_d = byte_w;
						wmask_d = FULL_MASK;
					end
					ST_MASK: begin
						mask_d = byte_w;
						st_d   = ST_BMDATA;
					end
					ST_BMDATA: begin
						wr_d    = 1'b1;
						wdata_d = byte_w;
						wmask_d = bitmod_ok ? mask_q : FULL_MASK;
						st_d    = ST_IGNORE;
					end
					ST_RDSTAT: begin
						nxt_d   = read_status;
						bdone_d = 1'b1;
					end
					ST_RXSTAT: begin
						nxt_d   = rx_status;
						bdone_d = 1'b1;
					end
					ST_IGNORE: begin
						st_d = ST_IGNORE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q       <= ST_CMD;
			op_q       <= OP_READ;
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
			bit_q      <= '0;
			in_q       <= '0;
			addr_q     <= BYTE_ZERO;
			out_q      <= BYTE_ZERO;
			nxt_q      <= BYTE_ZERO;
			bdone_q    <= 1'b0;
			rd_q       <= 1'b0;
			wr_q       <= 1'b0;
			wdata_q    <= BYTE_ZERO;
			wmask_q    <= BYTE_ZERO;
			mask_q     <= BYTE_ZERO;
			tx_request_flag_q    <= '0;
			rxclr_q    <= '0;
			rxsel_q    <= 1'b0;
			rxrd_q     <= 1'b0;
			rstp_q     <= 1'b0;
			srst_q     <= 1'b0;
			oe_q       <= 1'b0;
		end else begin
			st_q       <= st_d;
			op_q       <= op_d;
			sck_prev_q <= sck_prev_d;
			cs_prev_q  <= cs_prev_d;
			bit_q      <= bit_d;
			in_q       <= in_d;
			addr_q     <= addr_d;
			out_q      <= out_d;
			nxt_q      <= nxt_d;
			bdone_q    <= bdone_d;
			rd_q       <= rd_d;
			wr_q       <= wr_d;
			wdata_q    <= wdata_d;
			wmask_q    <= wmask_d;
			mask_q     <= mask_d;
			tx_request_flag_q    <= tx_request_flag_d;
			rxclr_q    <= rxclr_d;
			rxsel_q    <= rxsel_d;
			rxrd_q     <= rxrd_d;
			rstp_q     <= rstp_d;
			srst_q     <= srst_d;
			oe_q       <= oe_d;
		end
	end

	assign spi_so              = out_q[7];
	assign spi_so_oe           = oe_q;
	assign reg_addr            = addr_q;
	assign reg_rd              = rd_q;
	assign reg_wr              = wr_q;
	assign reg_wdata           = wdata_q;
	assign reg_wmask           = wmask_q;
	assign soft_reset          = srst_q;
	assign tx_request_flag_set = tx_request_flag_q;
	assign rx_full_flag_clear  = rxclr_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_rts_sets_bits: assert property (done_w && st_q == ST_CMD
		&& (byte_w & RTS_MASK) == RTS_PATTERN && byte_w[2:0] != 3'h0
		|=> tx_request_flag_set == $past(byte_w[2:0]))
		else $error("send request bits not set");
	a_rts_zero_ignored: assert property (done_w && st_q == ST_CMD && byte_w == RTS_PATTERN
		|=> tx_request_flag_set == 3'h0)
		else $error("empty send request changed requests");
	a_write_commit: assert property (done_w && st_q == ST_WR
		|=> reg_wr && reg_wdata == $past(byte_w) && reg_wmask == FULL_MASK
		&& reg_addr == $past(reg_addr))
		else $error("write byte not committed");
	a_wr_ptr_step: assert property (reg_wr && st_q == ST_WR
		|=> reg_addr == $past(reg_addr) + 8'h01)
		else $error("write pointer did not step");
	a_partial_dropped: assert property (cs_rise |=> !reg_wr [*2])
		else $error("write after deselect");
	a_ptr_advance: assert property (done_w && st_q == ST_RD
		|=> reg_addr == $past(reg_addr) + 8'h01 && reg_rd)
		else $error("pointer did not advance");
	a_rx_flag_clear: assert property (cs_rise && rxrd_q
		|=> rx_full_flag_clear == (rxsel_q ? 2'b01 << 1 : 2'b01))
		else $error("rx full flag not cleared");
	a_soft_reset: assert property (cs_rise && rstp_q |=> soft_reset ##1 !soft_reset)
		else $error("reset command pulse wrong");
	a_bitmod_mask: assert property (done_w && st_q == ST_BMDATA
		|=> reg_wr && reg_wmask == ($past(bitmod_ok) ? $past(mask_q) : FULL_MASK))
		else $error("bit modify mask wrong");
	a_so_on_fall: assert property (cs_act && $past(cs_act) && $changed(out_q)
		|-> $past(fall_w))
		else $error("output moved off a falling edge");
	a_unknown_idle: assert property (done_w && st_q == ST_CMD && byte_w == FULL_MASK
		|=> st_q == ST_IGNORE && out_q == BYTE_ZERO)
		else $error("unknown instruction not ignored");

	c_read_byte: cover property (done_w && st_q == ST_RD);
	c_write_byte: cover property (done_w && st_q == ST_WR);
	c_rx_clear: cover property (cs_rise && rxrd_q);
	c_status_stream: cover property (done_w && st_q == ST_RDSTAT);
endmodule : csp_port

// ===== test/csp_host.sv
`timescale 1ns/1ps
module csp_host (
	input  wire logic sys_clk,
	input  wire logic spi_so,
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_si
);
	logic       cpol;
	logic [7:0] rx[$];

	initial begin
		cpol = 1'b0;
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : hold

	// bits may stop short of a byte boundary to cut a byte
	task automatic frame(input logic [7:0] tx[$], input int bits);
		logic [7:0] b;
		b = 8'h00;
		rx = {};
		spi_sck <= cpol;
		hold(4);
		spi_cs_n <= 1'b0;
		hold(4);
		for (int i = 0; i < bits; i++) begin
			spi_sck <= 1'b0;
			spi_si <= tx[i / 8][7 - i % 8];
			hold(4);
			spi_sck <= 1'b1;
			hold(4);
			// sampled late in the high phase, where the output cannot be moving
			b = {b[6:0], spi_so};
			if (i % 8 == 7) rx.push_back(b);
		end
		spi_sck <= cpol;
		hold(4);
		spi_cs_n <= 1'b1;
		spi_si <= ~spi_si;
		// deselect pulses land three edges late; let the bench count them first
		hold(6);
	endtask : frame
endmodule : csp_host

// ===== test/csp_port_tb.sv
`timescale 1ns/1ps
module csp_port_tb;
	import csp_pkg::*;
	logic       sys_clk, rst, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
	logic       reg_rd, reg_wr, bitmod_ok, soft_reset;
	csp_byte_t  reg_addr, reg_rdata, reg_wdata, reg_wmask, read_status, rx_status;
	csp_txsel_t tx_request_flag_set, tx_last;
	csp_rxsel_t rx_full_flag_clear, rx_last;
	csp_byte_t  mem[256];
	int         n_errors, tests_run, n_wr, n_tx, n_rst, n_rd, n_oe, s, o;

	csp_port dut (.sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_wmask(reg_wmask), .bitmod_ok(bitmod_ok), .read_status(read_status),
		.rx_status(rx_status), .soft_reset(soft_reset),
		.tx_request_flag_set(tx_request_flag_set), .rx_full_flag_clear(rx_full_flag_clear));
	csp_host host (.sys_clk(sys_clk), .spi_so(spi_so), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si));

	// register file stand-in: read data follows the pointer without delay
	assign reg_rdata = mem[reg_addr];

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (reg_wr) mem[reg_addr] <= (mem[reg_addr] & ~reg_wmask) | (reg_wdata & reg_wmask);
		n_wr <= n_wr + int'(reg_wr);
		n_rst <= n_rst + int'(soft_reset);
		n_rd <= n_rd + int'(reg_rd);
		n_oe <= n_oe + int'(spi_so_oe);
		if (|tx_request_flag_set) begin
			tx_last <= tx_request_flag_set;
			n_tx <= n_tx + 1;
		end
		if (|rx_full_flag_clear) rx_last <= rx_full_flag_clear;
	end

	task chk(input csp_byte_t got, input csp_byte_t exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task end_sim;
		$display("errors=%0d compares=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task t_write;
		host.frame({8'h02, 8'h10, 8'h55, 8'h66}, 32);
		host.frame({8'h02, 8'h20, 8'haa, 8'hbb}, 28);
		chk(mem[8'h10], 8'h55);
		chk(mem[8'h11], 8'h66);
		chk(mem[8'h20], 8'haa);
		chk(mem[8'h21], 8'h00);
	endtask : t_write

	task t_read(input logic mode);
		host.cpol = mode;
		s = n_rd;
		host.frame({8'h03, 8'h10, 8'h00, 8'h00}, 32);
		chk(8'(n_rd - s), 8'h03);
		chk(host.rx[2], 8'h55);
		chk(host.rx[3], 8'h66);
	endtask : t_read

	task t_bitmod;
		bitmod_ok <= 1'b1;
		host.frame({8'h05, 8'h10, 8'h0f, 8'ha3}, 32);
		chk(mem[8'h10], 8'h53);
		bitmod_ok <= 1'b0;
		host.frame({8'h05, 8'h11, 8'h0f, 8'ha3}, 32);
		chk(mem[8'h11], 8'ha3);
	endtask : t_bitmod

	task t_rts;
		for (int n = 0; n < 8; n++) begin
			s = n_tx;
			host.frame({8'h80 | 8'(n)}, 8);
			chk(8'(n_tx - s), (n == 0) ? 8'h00 : 8'h01);
			if (n > 0) chk({5'h00, tx_last}, 8'(n));
		end
	endtask : t_rts

	task t_rxread;
		for (int k = 0; k < 4; k++) begin
			mem[(k[1] ? 8'h71 : 8'h61) + (k[0] ? 8'h05 : 8'h00)] = 8'h10 + 8'(k);
			host.frame({8'h90 | 8'(k << 1), 8'h00}, 16);
			chk(host.rx[1], 8'h10 + 8'(k));
			chk({6'h00, rx_last}, k[1] ? 8'h02 : 8'h01);
		end
	endtask : t_rxread

	task t_txload;
		for (int k = 0; k < 6; k++) begin
			host.frame({8'h40 | 8'(k), 8'hc0 + 8'(k)}, 16);
			chk(mem[8'h31 + 8'(16 * (k / 2)) + 8'(5 * (k % 2))], 8'hc0 + 8'(k));
		end
	endtask : t_txload

	task t_status;
		host.frame({8'ha0, 8'h00, 8'h00}, 24);
		chk(host.rx[1], 8'h5a);
		chk(host.rx[2], 8'h5a);
		host.frame({8'hb0, 8'h00}, 16);
		chk(host.rx[1], 8'hc3);
	endtask : t_status

	task t_misc;
		s = n_wr;
		host.frame({8'hff, 8'h10, 8'h99}, 24);
		chk(8'(n_wr - s), 8'h00);
		chk(host.rx[2], 8'h00);
		s = n_rst;
		o = n_oe;
		host.frame({8'hc0}, 8);
		chk(8'(n_rst - s), 8'h01);
		chk(8'(n_oe - o), 8'h48);
		chk({7'h00, spi_so_oe}, 8'h00);
	endtask : t_misc

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		{n_errors, tests_run, n_wr, n_tx, n_rst, n_rd, n_oe} = '0;
		rst = 1'b1;
		bitmod_ok = 1'b0;
		read_status = 8'h5a;
		rx_status = 8'hc3;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_write();
		t_read(1'b0);
		t_read(1'b1);
		host.cpol = 1'b0;
		t_bitmod();
		t_rts();
		t_rxread();
		t_txload();
		t_status();
		t_misc();
		end_sim();
	end

	// about 4400 cycles of traffic expected
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_errors++;
		end_sim();
	end
endmodule : csp_port_tb
